/* File: hdl/sar_adc_consts.svh */
// constants of the conversion control block: offsets, reset values, field positions, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// register byte offsets on the bus, one aligned word each
`define SC_OFFSET          8'h00
`define RES_HIGH_OFFSET    8'h04
`define RES_LOW_OFFSET     8'h08
`define CLK_CFG_OFFSET     8'h0c

// reset values
`define SC_RESET           8'h1f
`define CLK_CFG_RESET      8'h00

// field positions
`define SC_DONE_BIT        7
`define SC_IRQ_EN_BIT      6
`define SC_CONT_BIT        5
`define SC_CHAN_LSB        0
`define CHAN_WIDTH         5

// channel codes
`define CHAN_PORTB_LAST    5'h07
`define CHAN_REF_HIGH      5'h1d
`define CHAN_REF_LOW       5'h1e
`define CHAN_OFF           5'h1f

// resolution codes
`define MODE_8BIT          2'h0
`define MODE_10BIT         2'h1

// timing: bus clock period in ns, the rest in converter clock cycles (sample times rounded up from 3.5 and 23.5)
`define HCLK_PERIOD_NS     100
`define SHORT_SAMPLE_CYC   6'h04
`define LONG_SAMPLE_CYC    6'h18
`define CONV_BIT_CYC       6'h14

`endif

/* File: hdl/sar_adc_pkg.sv */
// types shared by the conversion control block, its checker and the bench
// assumes the constants header sits beside it
`include "sar_adc_consts.svh"

package sar_adc_pkg;

  // status/control register layout
  typedef struct packed {
    logic       done;
    logic       irq_en;
    logic       cont;
    logic [4:0] chan;
  } sc_reg_t;

  // clock/configuration register layout
  typedef struct packed {
    logic       low_power;
    logic [1:0] div;
    logic       in_clk_sel;
    logic [1:0] mode;
    logic       long_sample;
    logic       async_en;
  } clk_reg_t;

  // analog input routing
  typedef struct packed {
    logic [7:0] port_pin;
    logic       ref_high;
    logic       ref_low;
    logic       isolate;
  } chan_route_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

endpackage : sar_adc_pkg

/* File: hdl/conv_timer.sv */
// conversion timer: divides hclk into the converter clock and times sample plus conversion
// assumes start and abort come from logic on hclk, one-cycle pulses
`include "sar_adc_consts.svh"

module conv_timer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [1:0] div,
  input  wire logic       long_sample,
  output logic            sampling,
  output logic            done
);

  typedef struct packed {
    logic [2:0] prescale;
    logic [5:0] count;
    logic       busy;
    logic       sampling;
    logic       done;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  // last prescale count for divide by 1, 2, 4, 8
  function automatic logic [2:0] div_last(input logic [1:0] d);
    case (d)
      2'h0:    div_last = 3'h0;
      2'h1:    div_last = 3'h1;
      2'h2:    div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  endfunction : div_last

  logic [5:0] sample_len;
  logic [5:0] total_len;

  // sample length set by the long sample option
  always_comb begin
    sample_len = long_sample ? `LONG_SAMPLE_CYC : `SHORT_SAMPLE_CYC;
    total_len  = sample_len + `CONV_BIT_CYC;
  end

  // next state: restart wins over abort, tick on each converter clock
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.prescale = 3'h0;
      next_st.count    = 6'h00;
      next_st.busy     = 1'b1;
      next_st.sampling = 1'b1;
    end else if (abort) begin
      next_st.busy     = 1'b0;
      next_st.sampling = 1'b0;
    end else if (st.busy) begin
      if (st.prescale == div_last(div)) begin
        next_st.prescale = 3'h0;
        next_st.count    = st.count + 6'h01;
        if (st.count + 6'h01 == sample_len) begin
          next_st.sampling = 1'b0;
        end
        if (st.count + 6'h01 == total_len) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end
      end else begin
        next_st.prescale = st.prescale + 3'h1;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sampling = st.sampling;
  assign done     = st.done;

endmodule : conv_timer

/* File: hdl/sar_adc_ctrl.sv */
// status/control logic of a 10-bit successive-approximation converter, AHB-Lite slave
// assumes stop_mode, break_active and break_clear_enable come from logic on hclk;
// analog_code comes from the analog array and is synchronised here
//
// Functional notes
// - any control write aborts and restarts, unless channel is all ones
// - done flag is read-only and set at each conversion end
// - done flag clears on control write or low result read
// - interrupt request at conversion end when enabled; cleared by low result read or control write
// - continuous bit with valid channel converts back-to-back, updating results
// - continuous stops on reset, stop without async clock, clock write, control write
// - after stop abort, conversions resume only on a new control write
// - continuous clear: each valid control write makes exactly one conversion
// - five-bit channel: port pins 0-7, high ref, low ref, all ones off
// - all-ones channel powers converter off and isolates the pad
// - converter powers off by itself after each non-continuous conversion; low power output is the clock register bit
// - break-clear enable set: clears during break take effect and stay
// - break-clear enable clear: accesses in break leave status bits alone
// - interlock armed before break holds through it, released by later read
// - no hardware trigger: only control writes and continuous restarts at conversion end start conversions
// - 10-bit mode: high read blocks result loads until low read
// - resolution 00 is 8-bit, 01 is 10-bit, reset picks 8-bit
// - stop without async clock aborts; results keep last completed value
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`include "sar_adc_consts.svh"

module sar_adc_ctrl (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      ce,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [31:0]                    hrdata,
  output logic                           hresp,
  input  wire logic                      stop_mode,
  input  wire logic                      break_active,
  input  wire logic                      break_clear_enable,
  input  wire logic [9:0]                analog_code,
  output logic                           conv_irq,
  output logic                           conv_powered,
  output logic                           conv_sampling,
  output logic                           conv_low_power,
  output sar_adc_pkg::chan_route_t       chan_route
);

  typedef struct packed {
    sar_adc_pkg::sc_reg_t      sc;
    sar_adc_pkg::clk_reg_t     clk;
    sar_adc_pkg::conv_state_t  fsm;
    logic [9:0]                result;
    logic                      hold;
    logic                      irq;
    logic                      powered;
    sar_adc_pkg::chan_route_t  route;
    logic [9:0]                code_meta;
    logic [9:0]                code_sync;
    logic                      wr_pend;
    logic [7:0]                wr_addr;
    logic                      hreadyout;
    logic [31:0]               hrdata;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic t_start;
  logic t_abort;
  logic t_done;
  logic t_sampling;

  // channel code to analog routing
  function automatic sar_adc_pkg::chan_route_t decode_chan(input logic [4:0] c, input logic on);
    sar_adc_pkg::chan_route_t r;
    r          = '0;
    r.isolate  = (c == `CHAN_OFF) || !on;
    if (on && c <= `CHAN_PORTB_LAST) begin
      r.port_pin[c[2:0]] = 1'b1;
    end
    r.ref_high = on && (c == `CHAN_REF_HIGH);
    r.ref_low  = on && (c == `CHAN_REF_LOW);
    decode_chan = r;
  endfunction : decode_chan

  // true when a channel code may start a conversion
  function automatic logic chan_runs(input logic [4:0] c);
    chan_runs = (c != `CHAN_OFF);
  endfunction : chan_runs

  logic        protect;
  logic        addr_ok;
  logic [7:0]  a_off;
  logic [7:0]  rd_byte;
  logic [9:0]  new_result;
  logic        wr_sc;
  logic        wr_clk;
  logic        stop_abort;

  // bus decode and read data selection
  always_comb begin
    protect  = break_active && !break_clear_enable;
    addr_ok  = hsel && hready && htrans[1];
    a_off    = haddr[7:0];
    wr_sc    = st.wr_pend && (st.wr_addr == `SC_OFFSET);
    wr_clk   = st.wr_pend && (st.wr_addr == `CLK_CFG_OFFSET);
    stop_abort = stop_mode && !st.clk.async_en;
    case (a_off)
      `SC_OFFSET:       rd_byte = st.sc;
      `RES_HIGH_OFFSET: rd_byte = (st.clk.mode == `MODE_10BIT) ? {6'h00, st.result[9:8]} : 8'h00;
      `RES_LOW_OFFSET:  rd_byte = st.result[7:0];
      `CLK_CFG_OFFSET:  rd_byte = st.clk;
      default:          rd_byte = 8'h00;
    endcase
    // right-justified result in the chosen resolution
    if (st.clk.mode == `MODE_10BIT) begin
      new_result = st.code_sync;
    end else begin
      new_result = {2'h0, st.code_sync[9:2]};
    end
  end

  // next state of the whole block
  always_comb begin
    next_st           = st;
    t_start           = 1'b0;
    t_abort           = 1'b0;
    next_st.code_meta = analog_code;
    next_st.code_sync = st.code_meta;
    next_st.hreadyout = 1'b1;
    next_st.wr_pend   = addr_ok && hwrite;

    // address phase: reads answer next cycle, side effects taken now
    if (addr_ok) begin
      next_st.wr_addr = a_off;
      if (!hwrite) begin
        next_st.hrdata = {24'h000000, rd_byte};
        if (a_off == `RES_HIGH_OFFSET && st.clk.mode == `MODE_10BIT && !protect) begin
          next_st.hold = 1'b1;
        end
        if (a_off == `RES_LOW_OFFSET && !protect) begin
          next_st.hold   = 1'b0;
          next_st.sc.done = 1'b0;
          next_st.irq    = 1'b0;
        end
      end
    end

    // data phase of a control or clock write: register fields and status clears
    if (wr_sc) begin
      next_st.sc.irq_en = hwdata[`SC_IRQ_EN_BIT];
      next_st.sc.cont   = hwdata[`SC_CONT_BIT];
      next_st.sc.chan   = hwdata[`SC_CHAN_LSB +: `CHAN_WIDTH];
      if (!protect) begin
        next_st.sc.done = 1'b0;
        next_st.irq     = 1'b0;
      end
    end
    if (wr_clk) begin
      next_st.clk = hwdata[7:0];
    end

    // conversion end: set wins over any clear in the same cycle
    if (t_done) begin
      next_st.sc.done = 1'b1;
      if (st.sc.irq_en) begin
        next_st.irq = 1'b1;
      end
      if (!(st.hold && st.clk.mode == `MODE_10BIT)) begin
        next_st.result = new_result;
      end
    end

    // sequencing
    case (st.fsm)
      sar_adc_pkg::ST_IDLE: begin
        if (wr_sc && chan_runs(hwdata[`SC_CHAN_LSB +: `CHAN_WIDTH])) begin
          t_start     = 1'b1;
          next_st.fsm = sar_adc_pkg::ST_CONVERT;
        end
      end
      sar_adc_pkg::ST_CONVERT: begin
        if (wr_sc) begin
          t_abort = 1'b1;
          if (chan_runs(hwdata[`SC_CHAN_LSB +: `CHAN_WIDTH])) begin
            t_start = 1'b1;
          end else begin
            next_st.fsm = sar_adc_pkg::ST_IDLE;
          end
        end else if (wr_clk || stop_abort) begin
          t_abort     = 1'b1;
          next_st.fsm = sar_adc_pkg::ST_IDLE;
        end else if (t_done) begin
          if (st.sc.cont && chan_runs(st.sc.chan)) begin
            t_start = 1'b1;
          end else begin
            next_st.fsm = sar_adc_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        t_abort     = 1'b1;
        next_st.fsm = sar_adc_pkg::ST_IDLE;
      end
    endcase

    next_st.powered = (next_st.fsm == sar_adc_pkg::ST_CONVERT);
    next_st.route   = decode_chan(next_st.sc.chan, next_st.powered);
  end

  // state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.sc        <= `SC_RESET;
      st.clk       <= `CLK_CFG_RESET;
      st.fsm       <= sar_adc_pkg::ST_IDLE;
      st.hreadyout <= 1'b1;
      st.route     <= 11'h001;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // sample and conversion timing
  conv_timer u_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .start       (t_start),
    .abort       (t_abort),
    .div         (st.clk.div),
    .long_sample (st.clk.long_sample),
    .sampling    (t_sampling),
    .done        (t_done)
  );

  // outputs straight from flip-flops; hresp is tied low
  assign hreadyout      = st.hreadyout;
  assign hrdata         = st.hrdata;
  assign hresp          = 1'b0;
  assign conv_irq       = st.irq;
  assign conv_powered   = st.powered;
  assign conv_sampling  = t_sampling;
  assign conv_low_power = st.clk.low_power;
  assign chan_route     = st.route;

endmodule : sar_adc_ctrl

/* File: verification/sar_adc_ctrl_props.sv */
// checker: conversion, routing and interrupt relations at the control block's ports
// assumes a single hclk domain; bound onto every sar_adc_ctrl instance
module sar_adc_ctrl_props (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     ce,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [31:0]              hwdata,
  input wire logic                     hready,
  input wire logic                     break_active,
  input wire logic                     break_clear_enable,
  input wire logic                     conv_irq,
  input wire logic                     conv_powered,
  input wire sar_adc_pkg::chan_route_t chan_route
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // status protected during break
  wire logic prot = break_active && !break_clear_enable;
  wire logic acc  = ce && hsel && hready && htrans[1];

  // address phases of a control write and a low result read
  sequence sc_wr;
    acc && hwrite && haddr[7:0] == 8'h00;
  endsequence
  sequence lo_rd;
    acc && !hwrite && haddr[7:0] == 8'h08;
  endsequence

  start_conv_a: assert property (sc_wr ##1 hwdata[4:0] != 5'h1f |=> conv_powered)
    else $error("control write did not start a conversion");
  off_write_a: assert property (sc_wr ##1 hwdata[4:0] == 5'h1f |=> !conv_powered)
    else $error("all-ones channel left converter on");
  idle_isolate_a: assert property (!conv_powered && $past(!conv_powered) |-> chan_route.isolate)
    else $error("input not isolated while idle");
  route_sel_a: assert property (conv_powered && $past(conv_powered) |->
      !chan_route.isolate && $onehot({chan_route.port_pin, chan_route.ref_high, chan_route.ref_low}))
    else $error("converter routed to no single input");
  irq_wrclr_a: assert property (sc_wr ##1 !prot |=> !conv_irq)
    else $error("control write left request up");
  irq_keep_a: assert property (sc_wr ##0 prot ##1 prot |=> $stable(conv_irq))
    else $error("request changed in protected break");
  lowrd_clr_a: assert property (lo_rd ##0 !(prot || conv_powered) ##1 !prot |=> !conv_irq)
    else $error("low result read left request up");
  irq_fall_a: assert property ($fell(conv_irq) |-> $past(acc, 1) || $past(acc, 2))
    else $error("request dropped without an access");
endmodule : sar_adc_ctrl_props

bind sar_adc_ctrl sar_adc_ctrl_props props (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .break_active(break_active),
  .break_clear_enable(break_clear_enable), .conv_irq(conv_irq), .conv_powered(conv_powered),
  .chan_route(chan_route)
);

/* File: verification/tb_top.sv */
// bench: drives the conversion control block over AHB-Lite and checks its results
// assumes the package, header and checker are compiled before it
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [4:0]  ch;
    logic [9:0]  code;
    logic [10:0] route;
  } row_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, stop_mode = 1'b0;
  logic        break_active = 1'b0, break_clear_enable = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [9:0]  analog_code = 10'h000;
  logic        hreadyout, hresp, conv_irq, conv_powered, conv_sampling, conv_low_power;
  sar_adc_pkg::chan_route_t chan_route;
  int          err_total = 0, n_compared = 0;
  row_t        rows [4] = '{'{5'h00, 10'h3fc, 11'h008}, '{5'h07, 10'h155, 11'h400},
                            '{5'h1d, 10'h0aa, 11'h004}, '{5'h1e, 10'h2c3, 11'h002}};

  // 10 MHz bus clock
  always #50 hclk = ~hclk;

  sar_adc_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .stop_mode(stop_mode), .break_active(break_active),
    .break_clear_enable(break_clear_enable), .analog_code(analog_code), .conv_irq(conv_irq),
    .conv_powered(conv_powered), .conv_sampling(conv_sampling), .conv_low_power(conv_low_power),
    .chan_route(chan_route)
  );

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: register read %h, want %h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_sig(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: port shows %h, want %h", $time, got, exp);
    end
  endtask : chk_sig

  // one single word transfer, waiting on ready in both phases
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk_reg(rd, exp);
  endtask : rd_chk

  // bounded wait for the conversion request, then check that it is up
  task wait_irq;
    @(negedge hclk);
    for (int k = 0; k < 300 && conv_irq !== 1'b1; k++) @(negedge hclk);
    chk_sig({10'h0, conv_irq}, 11'h001);
  endtask : wait_irq

  task settle_pow(input logic exp);
    repeat (3) @(negedge hclk);
    chk_sig({10'h0, conv_powered}, {10'h0, exp});
  endtask : settle_pow

  task give_verdict;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk_sig(chan_route, 11'h001);
    chk_sig({9'h0, hresp, conv_low_power}, 11'h000);
    rd_chk(8'h00, 32'h1f);
    rd_chk(8'h0c, 32'h00);
    rd_chk(8'h10, 32'h00);
    // single conversions on each routed channel kind
    foreach (rows[i]) begin
      analog_code <= rows[i].code;
      bus(8'h00, 1'b1, {3'b010, rows[i].ch});
      repeat (2) @(negedge hclk);
      chk_sig(chan_route, rows[i].route);
      chk_sig({10'h0, conv_sampling}, 11'h001);
      wait_irq;
      rd_chk(8'h00, {24'h0, 3'b110, rows[i].ch});
      settle_pow(1'b0);
      rd_chk(8'h08, {24'h0, rows[i].code[9:2]});
      settle_pow(1'b0);
      chk_sig({10'h0, conv_irq}, 11'h000);
      rd_chk(8'h00, {24'h0, 3'b010, rows[i].ch});
    end
    // 10-bit mode and the high/low interlock
    bus(8'h0c, 1'b1, 8'h04);
    analog_code <= 10'h2a5;
    bus(8'h00, 1'b1, 8'h40);
    wait_irq;
    rd_chk(8'h04, 32'h02);
    analog_code <= 10'h15a;
    bus(8'h00, 1'b1, 8'h40);
    wait_irq;
    rd_chk(8'h08, 32'ha5);
    bus(8'h00, 1'b1, 8'h40);
    wait_irq;
    rd_chk(8'h08, 32'h5a);
    // continuous conversions, then stop mode
    bus(8'h00, 1'b1, 8'h60);
    wait_irq;
    rd_chk(8'h08, 32'h5a);
    analog_code <= 10'h0c3;
    wait_irq;
    rd_chk(8'h08, 32'hc3);
    chk_sig({10'h0, conv_powered}, 11'h001);
    stop_mode <= 1'b1;
    settle_pow(1'b0);
    stop_mode <= 1'b0;
    repeat (60) @(posedge hclk);
    settle_pow(1'b0);
    rd_chk(8'h08, 32'hc3);
    // continuous ended by a clock register write, then by the off code
    bus(8'h00, 1'b1, 8'h60);
    bus(8'h0c, 1'b1, 8'h04);
    settle_pow(1'b0);
    bus(8'h00, 1'b1, 8'h60);
    bus(8'h00, 1'b1, 8'h7f);
    settle_pow(1'b0);
    chk_sig({10'h0, chan_route.isolate}, 11'h001);
    repeat (60) @(posedge hclk);
    settle_pow(1'b0);
    // protected break keeps status, later read clears it
    bus(8'h00, 1'b1, 8'h40);
    wait_irq;
    break_active <= 1'b1;
    rd_chk(8'h08, 32'hc3);
    rd_chk(8'h00, 32'hc0);
    chk_sig({10'h0, conv_irq}, 11'h001);
    bus(8'h00, 1'b1, 8'h5f);
    rd_chk(8'h00, 32'hdf);
    chk_sig({10'h0, conv_irq}, 11'h001);
    break_active <= 1'b0;
    bus(8'h08, 1'b0, 8'h00);
    settle_pow(1'b0);
    chk_sig({10'h0, conv_irq}, 11'h000);
    // break with clearing allowed
    bus(8'h00, 1'b1, 8'h40);
    wait_irq;
    break_active <= 1'b1;
    break_clear_enable <= 1'b1;
    bus(8'h08, 1'b0, 8'h00);
    settle_pow(1'b0);
    chk_sig({10'h0, conv_irq}, 11'h000);
    break_active <= 1'b0;
    rd_chk(8'h00, 32'h40);
    give_verdict;
  end
endmodule : tb_top
